// ### cfgio_pkg.sv
// constants, types and register map of the configurable io port
package cfgio_pkg;
  // ==========================================================
  // widths
  localparam int NPIN = 8;                       // pins in one port
  localparam int NUSB = 2;                       // usb capable pins
  localparam int AW   = 8;                       // register address width
  localparam int DW   = 16;                      // register data width

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_OUT_DATA = 8'h00;   // port_out_data_reg
  localparam logic [7:0] OFS_PIN_STAT = 8'h04;   // pin_state_read, read only
  localparam logic [7:0] OFS_DM0      = 8'h08;   // drive mode bit 0 plane
  localparam logic [7:0] OFS_DM1      = 8'h0c;   // drive mode bit 1 plane
  localparam logic [7:0] OFS_DM2      = 8'h10;   // drive mode bit 2 plane
  localparam logic [7:0] OFS_BYPASS   = 8'h14;   // fabric bypass select
  localparam logic [7:0] OFS_RISE_EN  = 8'h18;   // rising edge enables
  localparam logic [7:0] OFS_FALL_EN  = 8'h1c;   // falling edge enables
  localparam logic [7:0] OFS_PEND     = 8'h20;   // pending flags, write 1 clears
  localparam logic [7:0] OFS_USB_CTL  = 8'h24;   // usb pin control
  localparam logic [7:0] OFS_USB_STAT = 8'h28;   // usb state and pending
  localparam logic [7:0] OFS_PIN_BASE = 8'h40;   // per pin views, one word per pin
  localparam logic [7:0] OFS_PIN_LAST = 8'h5c;   // last per pin view

  // ==========================================================
  // per pin view fields
  localparam int PV_DM   = 0;                    // [2:0] drive mode
  localparam int PV_DATA = 3;                    // output data bit
  localparam int PV_BYP  = 4;                    // bypass select
  localparam int PV_RISE = 5;                    // rising edge enable
  localparam int PV_FALL = 6;                    // falling edge enable
  localparam int PV_PEND = 7;                    // pending, write 1 clears
  localparam int PV_STAT = 8;                    // pin level, read only

  // usb control fields
  localparam int UC_PP   = 0;                    // [1:0] push pull enables
  localparam int UC_DATA = 2;                    // [3:2] output data
  localparam int UC_RISE = 4;                    // [5:4] rising enables
  localparam int UC_FALL = 6;                    // [7:6] falling enables
  localparam int US_PEND = 2;                    // [3:2] usb pending in status

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_OUT_DATA = 8'h00;  // default port data
  localparam logic [23:0] RST_DM       = 24'h00_0000; // default: all analog high z
  localparam logic [7:0]  RST_BYTE     = 8'h00;  // other byte registers

  // ==========================================================
  // drive modes, codes follow declaration order 0..7
  typedef enum logic [2:0] {
    DM_HIZ_ANA, DM_HIZ_DIG, DM_RES_UP, DM_RES_DN,
    DM_OD_LO, DM_OD_HI, DM_STRONG, DM_RES_BOTH
  } cfgio_dm_t;
endpackage : cfgio_pkg

// ### cfgio_pin_if.sv
// bundle between the port core and one pin driver
interface cfgio_pin_if;
  import cfgio_pkg::*;
  cfgio_dm_t dm;        // selected drive mode
  logic      dout;      // data after bypass mux
  logic      pad_out;   // driven level
  logic      pad_oe;    // strong drive enable
  logic      pad_pu;    // resistive pull up enable
  logic      pad_pd;    // resistive pull down enable
  // core side
  modport ctl (output dm, dout, input pad_out, pad_oe, pad_pu, pad_pd);
  // driver side
  modport drv (input dm, dout, output pad_out, pad_oe, pad_pu, pad_pd);
endinterface : cfgio_pin_if

// ### cfgio_pin_drv.sv
// one pin: drive mode and data to registered pad controls
module cfgio_pin_drv (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // core bundle
  cfgio_pin_if.drv p
);
  import cfgio_pkg::*;

  // ==========================================================
  // drive decode, registered so pads come from flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p.pad_out <= 1'b0;
      p.pad_oe  <= 1'b0;
      p.pad_pu  <= 1'b0;
      p.pad_pd  <= 1'b0;
    end else begin
      p.pad_out <= p.dout;                                  // RL2
      case (p.dm)
        DM_HIZ_ANA, DM_HIZ_DIG: begin                       // RL1
          p.pad_oe <= 1'b0;
          p.pad_pu <= 1'b0;
          p.pad_pd <= 1'b0;
        end
        DM_RES_UP: begin                                    // RL5
          p.pad_oe <= ~p.dout;
          p.pad_pu <= p.dout;
          p.pad_pd <= 1'b0;
        end
        DM_RES_DN: begin                                    // RL5
          p.pad_oe <= p.dout;
          p.pad_pu <= 1'b0;
          p.pad_pd <= ~p.dout;
        end
        DM_OD_LO: begin                                     // RL3
          p.pad_oe <= ~p.dout;
          p.pad_pu <= 1'b0;
          p.pad_pd <= 1'b0;
        end
        DM_OD_HI: begin                                     // RL4
          p.pad_oe <= p.dout;
          p.pad_pu <= 1'b0;
          p.pad_pd <= 1'b0;
        end
        DM_STRONG: begin                                    // RL4
          p.pad_oe <= 1'b1;
          p.pad_pu <= 1'b0;
          p.pad_pd <= 1'b0;
        end
        default: begin                                      // resistive both
          p.pad_oe <= 1'b0;
          p.pad_pu <= p.dout;
          p.pad_pd <= ~p.dout;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  hiz_mode_a: assert property (@(posedge clk) disable iff (rst) // RL1
    (p.dm == DM_HIZ_ANA || p.dm == DM_HIZ_DIG) |=> !(p.pad_oe || p.pad_pu || p.pad_pd))
    else $error("high z mode drives the pin");
  od_low_a: assert property (@(posedge clk) disable iff (rst) // RL3
    (p.dm == DM_OD_LO) |=> (p.pad_oe == !$past(p.dout)) && p.pad_out == $past(p.dout))
    else $error("open drain low mode wrong");
  res_both_a: assert property (@(posedge clk) disable iff (rst) // RL5
    (p.dm == DM_RES_BOTH) |=> !p.pad_oe && (p.pad_pu != p.pad_pd))
    else $error("resistive mode uses strong drive");
endmodule : cfgio_pin_drv

// ### cfgio_edge_irq.sv
// edge detect with sticky pending flags per bit
module cfgio_edge_irq #(
  parameter int W = 8                        // number of pins watched
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // levels and controls
  input  wire logic [W-1:0] lvl,             // synchronised pin levels
  input  wire logic [W-1:0] rise_en,         // rising edge enables
  input  wire logic [W-1:0] fall_en,         // falling edge enables
  input  wire logic [W-1:0] clr,             // clear strobes
  // result
  output logic      [W-1:0] pend             // sticky pending flags
);
  logic [W-1:0] prev_q;                      // level one cycle ago
  logic         armed_q;                     // prev_q holds a real sample
  logic [W-1:0] hit;                         // edge seen this cycle

  // edge match, ignored until a first sample exists
  assign hit = {W{armed_q}} & ((rise_en & lvl & ~prev_q)
                             | (fall_en & ~lvl & prev_q));   // RL8

  // ==========================================================
  // history of levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q  <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= lvl;
      armed_q <= 1'b1;
    end
  end

  // ==========================================================
  // pending flags: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~clr) | hit;                            // RL14
    end
  end

  // ==========================================================
  // checks
  edge_set_a: assert property (@(posedge clk) disable iff (rst) // RL8
    (armed_q && (rise_en[0] && lvl[0] && !prev_q[0]
                 || fall_en[0] && !lvl[0] && prev_q[0])) |=> pend[0])
    else $error("edge did not set pending");
  pend_hold_a: assert property (@(posedge clk) disable iff (rst) // RL14
    (pend[0] && !clr[0]) |=> pend[0])
    else $error("pending flag dropped without clear");
endmodule : cfgio_edge_irq

// ### cfgio_port.sv
// configurable io port: registers, pin drivers and port interrupts
// What this block does
// RL1: each pin has eight mode selector; 000/001 float
// RL2: pin follows data register or bypass fabric signal
// RL3: mode 100 drives low, floats high
// RL4: mode 101 drives high only; 110 both
// RL5: modes 010, 011, 111 use resistive pulls
// RL6: drive modes take configured values at reset
// RL7: port reset state is user configurable
// RL8: per pin rising, falling or both edge interrupts
// RL9: pin interrupts merge into one port request
// RL10: pin state read separately from output data
// RL11: whole port and per pin register views
// RL12: peripherals use fabric; cpu uses registers
// RL13: usb pins add push pull and edge interrupts
// RL14: edge sets pending flag until software clears
module cfgio_port #(
  parameter logic [7:0]  PORT_RESET_DATA = cfgio_pkg::RST_OUT_DATA, // user reset data
  parameter logic [23:0] PORT_RESET_DM   = cfgio_pkg::RST_DM        // user reset modes
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // register port
  input  wire logic [cfgio_pkg::AW-1:0]      reg_addr,
  input  wire logic [cfgio_pkg::DW-1:0]      reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [cfgio_pkg::DW-1:0]      reg_rdata,
  // general pins
  input  wire logic [cfgio_pkg::NPIN-1:0]    pad_in,
  output logic      [cfgio_pkg::NPIN-1:0]    pad_out,
  output logic      [cfgio_pkg::NPIN-1:0]    pad_oe,
  output logic      [cfgio_pkg::NPIN-1:0]    pad_pu,
  output logic      [cfgio_pkg::NPIN-1:0]    pad_pd,
  // usb capable pins
  input  wire logic [cfgio_pkg::NUSB-1:0]    usb_pad_in,
  output logic      [cfgio_pkg::NUSB-1:0]    usb_pad_out,
  output logic      [cfgio_pkg::NUSB-1:0]    usb_pad_oe,
  // routed digital fabric
  input  wire logic [cfgio_pkg::NPIN-1:0]    fab_out,
  output logic      [cfgio_pkg::NPIN-1:0]    fab_in,
  // interrupt requests
  output logic                               port_irq,
  output logic                               usb_irq
);
  import cfgio_pkg::*;

  // ==========================================================
  // state
  logic [NPIN-1:0] out_data_q;               // port_out_data_reg
  logic [NPIN-1:0] dm0_q, dm1_q, dm2_q;      // drive mode planes
  logic [NPIN-1:0] byp_q;                    // bypass selects
  logic [NPIN-1:0] rise_q, fall_q;           // edge enables
  logic [NPIN-1:0] sync1_q, sync2_q;         // pin synchroniser
  logic [NUSB-1:0] usync1_q, usync2_q;       // usb pin synchroniser
  logic [7:0]      usb_ctl_q;                // usb control
  logic [NPIN-1:0] pend;                     // pending flags
  logic [NUSB-1:0] usb_pend;                 // usb pending flags
  logic [NPIN-1:0] pend_clr;                 // clear strobes
  logic [NUSB-1:0] usb_clr;                  // usb clear strobes
  logic [DW-1:0]   rdata_d;                  // read mux
  logic            pin_hit;                  // per pin view addressed
  logic [2:0]      pin_idx;                  // addressed pin
  logic [1:0]      warm_q;                   // cycles since reset release, stops at 2
  logic            sync_ok;                  // both sync stages hold pin samples

  // per pin view decode
  assign pin_hit = (reg_addr >= OFS_PIN_BASE) && (reg_addr <= OFS_PIN_LAST)
                   && (reg_addr[1:0] == 2'b00);
  assign pin_idx = reg_addr[4:2];

  // ==========================================================
  // input synchronisers, first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      usync1_q <= '0;
      usync2_q <= '0;
    end else begin
      sync1_q  <= pad_in;
      sync2_q  <= sync1_q;
      usync1_q <= usb_pad_in;
      usync2_q <= usync1_q;
    end
  end

  // edges count only once both stages hold real pin samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warm_q <= 2'h0;
    end else if (!sync_ok) begin
      warm_q <= warm_q + 2'h1;                              // RL8
    end
  end
  assign sync_ok = warm_q[1];

  // ==========================================================
  // fabric input path, peripherals see pins only here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fab_in <= '0;
    end else begin
      fab_in <= sync2_q;                                    // RL12
    end
  end

  // ==========================================================
  // configuration writes, whole port or per pin view
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_data_q <= PORT_RESET_DATA;                        // RL7
      dm0_q      <= PORT_RESET_DM[7:0];                     // RL6
      dm1_q      <= PORT_RESET_DM[15:8];
      dm2_q      <= PORT_RESET_DM[23:16];
      byp_q      <= RST_BYTE;
      rise_q     <= RST_BYTE;
      fall_q     <= RST_BYTE;
      usb_ctl_q  <= RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_OUT_DATA: out_data_q <= reg_wdata[7:0];
        OFS_DM0:      dm0_q      <= reg_wdata[7:0];         // RL11
        OFS_DM1:      dm1_q      <= reg_wdata[7:0];
        OFS_DM2:      dm2_q      <= reg_wdata[7:0];
        OFS_BYPASS:   byp_q      <= reg_wdata[7:0];
        OFS_RISE_EN:  rise_q     <= reg_wdata[7:0];
        OFS_FALL_EN:  fall_q     <= reg_wdata[7:0];
        OFS_USB_CTL:  usb_ctl_q  <= reg_wdata[7:0];         // RL13
        default: begin
          if (pin_hit) begin                                // RL11
            dm0_q[pin_idx]      <= reg_wdata[PV_DM];
            dm1_q[pin_idx]      <= reg_wdata[PV_DM+1];
            dm2_q[pin_idx]      <= reg_wdata[PV_DM+2];
            out_data_q[pin_idx] <= reg_wdata[PV_DATA];
            byp_q[pin_idx]      <= reg_wdata[PV_BYP];
            rise_q[pin_idx]     <= reg_wdata[PV_RISE];
            fall_q[pin_idx]     <= reg_wdata[PV_FALL];
          end
        end
      endcase
    end
  end

  // ==========================================================
  // write one to clear strobes for pending flags
  always_comb begin
    pend_clr = '0;
    usb_clr  = '0;
    if (reg_wr && reg_addr == OFS_PEND) begin
      pend_clr = reg_wdata[7:0];
    end
    if (reg_wr && pin_hit && reg_wdata[PV_PEND]) begin
      pend_clr[pin_idx] = 1'b1;
    end
    if (reg_wr && reg_addr == OFS_USB_STAT) begin
      usb_clr = reg_wdata[US_PEND+1:US_PEND];
    end
  end

  // ==========================================================
  // read mux; pin state comes from the pins, never from out_data_q
  always_comb begin
    rdata_d = '0;
    case (reg_addr)
      OFS_OUT_DATA: rdata_d[7:0] = out_data_q;
      OFS_PIN_STAT: rdata_d[7:0] = sync2_q;                 // RL10
      OFS_DM0:      rdata_d[7:0] = dm0_q;
      OFS_DM1:      rdata_d[7:0] = dm1_q;
      OFS_DM2:      rdata_d[7:0] = dm2_q;
      OFS_BYPASS:   rdata_d[7:0] = byp_q;
      OFS_RISE_EN:  rdata_d[7:0] = rise_q;
      OFS_FALL_EN:  rdata_d[7:0] = fall_q;
      OFS_PEND:     rdata_d[7:0] = pend;
      OFS_USB_CTL:  rdata_d[7:0] = usb_ctl_q;
      OFS_USB_STAT: rdata_d[3:0] = {usb_pend, usync2_q};
      default: begin
        if (pin_hit) begin
          rdata_d[PV_DM+2:PV_DM] = {dm2_q[pin_idx], dm1_q[pin_idx], dm0_q[pin_idx]};
          rdata_d[PV_DATA] = out_data_q[pin_idx];
          rdata_d[PV_BYP]  = byp_q[pin_idx];
          rdata_d[PV_RISE] = rise_q[pin_idx];
          rdata_d[PV_FALL] = fall_q[pin_idx];
          rdata_d[PV_PEND] = pend[pin_idx];
          rdata_d[PV_STAT] = sync2_q[pin_idx];
        end
      end
    endcase
  end

  // read data stand the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : '0;
    end
  end

  // ==========================================================
  // pin drivers, one per pin
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    cfgio_pin_if pif ();
    assign pif.dm   = cfgio_dm_t'({dm2_q[i], dm1_q[i], dm0_q[i]}); // RL1
    assign pif.dout = byp_q[i] ? fab_out[i] : out_data_q[i];      // RL2
    assign pad_out[i] = pif.pad_out;
    assign pad_oe[i]  = pif.pad_oe;
    assign pad_pu[i]  = pif.pad_pu;
    assign pad_pd[i]  = pif.pad_pd;
    cfgio_pin_drv u_drv (.clk(clk), .rst(rst), .p(pif.drv));
  end

  // usb pins: push pull when enabled, digital high z otherwise
  for (genvar j = 0; j < NUSB; j++) begin : g_usb
    cfgio_pin_if uif ();
    assign uif.dm   = usb_ctl_q[UC_PP+j] ? DM_STRONG : DM_HIZ_DIG; // RL13
    assign uif.dout = usb_ctl_q[UC_DATA+j];
    assign usb_pad_out[j] = uif.pad_out;
    assign usb_pad_oe[j]  = uif.pad_oe;
    cfgio_pin_drv u_drv (.clk(clk), .rst(rst), .p(uif.drv));
  end

  // ==========================================================
  // edge interrupts
  // enables held off until the synchronisers are warm; prev_q still holds 0 on that first cycle, so a high pin can flag a rising edge
  cfgio_edge_irq #(.W(NPIN)) u_edge (
    .clk(clk), .rst(rst), .lvl(sync2_q),
    .rise_en(rise_q & {NPIN{sync_ok}}),
    .fall_en(fall_q & {NPIN{sync_ok}}),
    .clr(pend_clr), .pend(pend)
  );
  cfgio_edge_irq #(.W(NUSB)) u_usb_edge (                  // RL13
    .clk(clk), .rst(rst), .lvl(usync2_q),
    .rise_en(usb_ctl_q[UC_RISE+1:UC_RISE] & {NUSB{sync_ok}}),
    .fall_en(usb_ctl_q[UC_FALL+1:UC_FALL] & {NUSB{sync_ok}}),
    .clr(usb_clr), .pend(usb_pend)
  );

  // one request for the general pins and one for the usb pins, each held while any of its flags is pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_irq <= 1'b0;
      usb_irq  <= 1'b0;
    end else begin
      port_irq <= |pend;                                    // RL9
      usb_irq  <= |usb_pend;
    end
  end

  // ==========================================================
  // checks
  sequence rd_pin_state_s;
    reg_rd && reg_addr == OFS_PIN_STAT;
  endsequence
  sequence wr_pin3_view_s;
    reg_wr && pin_hit && pin_idx == 3'h3;
  endsequence

  ps_read_a: assert property (@(posedge clk) disable iff (rst) // RL10
    rd_pin_state_s |=> reg_rdata[7:0] == $past(sync2_q))
    else $error("pin state read wrong");

  pin_view_a: assert property (@(posedge clk) disable iff (rst) // RL11
    wr_pin3_view_s |=> {dm2_q[3], dm1_q[3], dm0_q[3]} == $past(reg_wdata[2:0]))
    else $error("per pin view write lost");

  irq_comb_a: assert property (@(posedge clk) disable iff (rst) // RL9
    (|pend) |=> port_irq)
    else $error("port request missing");

  bypass_a: assert property (@(posedge clk) disable iff (rst) // RL2
    (byp_q[7] && dm0_q[7] == 1'b0 && dm1_q[7] && dm2_q[7]) |=>
      pad_out[7] == $past(fab_out[7]) && pad_oe[7])
    else $error("bypass data not driven");

  reset_state_a: assert property (@(posedge clk) // RL6
    $fell(rst) |-> {dm2_q, dm1_q, dm0_q} == {PORT_RESET_DM[23:16],
      PORT_RESET_DM[15:8], PORT_RESET_DM[7:0]} && out_data_q == PORT_RESET_DATA)
    else $error("reset state not applied");

  usb_pp_a: assert property (@(posedge clk) disable iff (rst) // RL13
    usb_ctl_q[UC_PP] |=> usb_pad_oe[0])
    else $error("usb push pull not driving");

  usb_irq_a: assert property (@(posedge clk) disable iff (rst) // RL13
    (|usb_pend) |=> usb_irq)
    else $error("usb request missing");

  fab_path_a: assert property (@(posedge clk) disable iff (rst) // RL12
    1'b1 |=> fab_in == $past(sync2_q))
    else $error("fabric input wrong");

  warm_gate_a: assert property (@(posedge clk) disable iff (rst) // RL8
    !sync_ok |=> pend == '0)
    else $error("edge flagged during warm up");

  rdata_idle_a: assert property (@(posedge clk) disable iff (rst) // RL11
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside read cycle");
endmodule : cfgio_port

// ### cfgio_pin_load.sv
// external load model seen by the port pins
module cfgio_pin_load (
  // clock
  input  wire logic                       clk,
  // pad controls from the port
  input  wire logic [cfgio_pkg::NPIN-1:0] pad_out,
  input  wire logic [cfgio_pkg::NPIN-1:0] pad_oe,
  input  wire logic [cfgio_pkg::NPIN-1:0] pad_pu,
  input  wire logic [cfgio_pkg::NPIN-1:0] pad_pd,
  // external source on the board
  input  wire logic [cfgio_pkg::NPIN-1:0] ext_en,
  input  wire logic [cfgio_pkg::NPIN-1:0] ext_val,
  // resolved pin levels back to the port
  output logic      [cfgio_pkg::NPIN-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import cfgio_pkg::*;

  // ==========================================================
  // floating pins wander so a high z never reads as a stable level
  logic [NPIN-1:0] wander_q = '0;  // changes every cycle

  always_ff @(posedge clk) begin
    wander_q <= ~wander_q;
  end

  // ==========================================================
  // strong drive beats the board, the board beats a resistive pull
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];       // strong level
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];       // board source
      end else if (pad_pu[i]) begin
        pad_in[i] = 1'b1;             // resistive high
      end else if (pad_pd[i]) begin
        pad_in[i] = 1'b0;             // resistive low
      end else begin
        pad_in[i] = wander_q[i];      // nobody drives
      end
    end
  end
endmodule : cfgio_pin_load

// ### cfgio_port_test.sv
// self-checking bench for the configurable io port
module cfgio_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cfgio_pkg::*;

  // ==========================================================
  // stimulus and observed signals
  logic            clk = 1'b0;     // 20 MHz
  logic            rst = 1'b1;     // async, high
  logic [AW-1:0]   reg_addr = '0;  // register address
  logic [DW-1:0]   reg_wdata = '0; // write data
  logic            reg_wr = 1'b0;  // write strobe
  logic            reg_rd = 1'b0;  // read strobe
  logic [DW-1:0]   reg_rdata;      // read data
  logic [NPIN-1:0] pad_in, pad_out, pad_oe, pad_pu, pad_pd, fab_in;
  logic [NPIN-1:0] ext_en = '0;    // board drives pins
  logic [NPIN-1:0] ext_val = '0;   // board level
  logic [NPIN-1:0] fab_out = '0;   // fabric data
  logic [NUSB-1:0] usb_pad_in = '0;
  logic [NUSB-1:0] usb_pad_out, usb_pad_oe;
  logic            port_irq, usb_irq;
  int              errors = 0;
  int              checks_done = 0;

  initial forever #25 clk = ~clk;

  // reset state chosen as strong drive with data a5
  cfgio_port #(.PORT_RESET_DATA(8'ha5), .PORT_RESET_DM(24'hff_ff00)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .usb_pad_in(usb_pad_in),
    .usb_pad_out(usb_pad_out), .usb_pad_oe(usb_pad_oe), .fab_out(fab_out),
    .fab_in(fab_in), .port_irq(port_irq), .usb_irq(usb_irq));

  cfgio_pin_load load_u (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .pad_pd(pad_pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // ==========================================================
  // expected {oe, pu, pd} per drive mode and data bit
  function automatic logic [2:0] exp_drv(input int m, input logic d);
    case (m)
      2: return d ? 3'b010 : 3'b100;  // resistive high, strong low
      3: return d ? 3'b100 : 3'b001;  // strong high, resistive low
      4: return d ? 3'b000 : 3'b100;  // low side only
      5: return d ? 3'b100 : 3'b000;  // high side only
      6: return 3'b100;               // strong both
      7: return d ? 3'b010 : 3'b001;  // resistive both
      default: return 3'b000;         // both high z modes
    endcase
  endfunction : exp_drv

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one cycle write strobe
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one cycle read strobe, data checked in the following cycle
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // bounded wait for a request line to reach a level
  task automatic wait_irq(input logic usb, input logic exp);
    int i;
    for (i = 0; i < 10; i++) begin
      if ((usb ? usb_irq : port_irq) === exp) break;
      @(posedge clk);
      #1;
    end
    if (i == 10) begin
      errors++;
      $display("ERROR irq expected %b seen timeout", exp);
      report_and_stop();
    end
  endtask : wait_irq

  // ==========================================================
  // main sequence
  initial begin
    logic [2:0] e;
    logic [7:0] eo, eu, ed;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    chk("reset pad_oe", 16'h00ff, {8'h00, pad_oe});
    chk("reset pad_out", 16'h00a5, {8'h00, pad_out});
    rd(OFS_DM1, 16'h00ff, "reset dm1");
    // every drive mode, pins 0..3 high and 4..7 low
    for (int m = 0; m < 8; m++) begin
      wr(OFS_DM0, {8'h00, {8{m[0]}}});
      wr(OFS_DM1, {8'h00, {8{m[1]}}});
      wr(OFS_DM2, {8'h00, {8{m[2]}}});
      wr(OFS_OUT_DATA, 16'h000f);
      settle(3);
      for (int p = 0; p < NPIN; p++) begin
        e = exp_drv(m, p < 4);
        {eo[p], eu[p], ed[p]} = e;
      end
      chk("pad_oe", {8'h00, eo}, {8'h00, pad_oe});
      chk("pad_pu", {8'h00, eu}, {8'h00, pad_pu});
      chk("pad_pd", {8'h00, ed}, {8'h00, pad_pd});
      chk("pad_out", 16'h000f, {8'h00, pad_out});
    end
    // pin state kept apart from output data
    wr(OFS_DM0, 16'h0000);
    wr(OFS_DM1, 16'h0000);
    wr(OFS_DM2, 16'h0000);
    wr(OFS_OUT_DATA, 16'h005a);
    ext_en <= 8'hff;
    ext_val <= 8'h96;
    settle(4);
    rd(OFS_PIN_STAT, 16'h0096, "pin state");
    rd(OFS_OUT_DATA, 16'h005a, "out data");
    chk("fab_in", 16'h0096, {8'h00, fab_in});
    // edge interrupts: bit0 rise, bit1 fall, bit2 both, bit3 none
    ext_val <= 8'h00;
    settle(4);
    wr(OFS_RISE_EN, 16'h0005);
    wr(OFS_FALL_EN, 16'h0006);
    wr(OFS_PEND, 16'h00ff);
    ext_val <= 8'h0f;
    wait_irq(1'b0, 1'b1);
    rd(OFS_PEND, 16'h0005, "pend after rise");
    wr(OFS_PEND, 16'h0001);
    rd(OFS_PEND, 16'h0004, "pend partial clear");
    chk("port_irq held", 16'h0001, {15'h0000, port_irq});
    ext_val <= 8'h00;
    settle(4);
    rd(OFS_PEND, 16'h0006, "pend after fall");
    wr(OFS_PEND, 16'h00ff);
    wait_irq(1'b0, 1'b0);
    // per pin view of pin 3: strong mode, data 1
    wr(OFS_PIN_BASE + 8'h0c, 16'h000e);
    settle(3);
    chk("pin view oe", 16'h0008, {8'h00, pad_oe});
    rd(OFS_PIN_BASE + 8'h0c, 16'h010e, "pin view");
    rd(OFS_DM2, 16'h0008, "dm2 from pin view");
    // bypass on upper pins takes fabric data
    wr(OFS_DM1, 16'h00ff);
    wr(OFS_DM2, 16'h00ff);
    wr(OFS_BYPASS, 16'h00f0);
    fab_out <= 8'h3c;
    settle(3);
    chk("bypass pad_out", 16'h003a, {8'h00, pad_out});
    wr(OFS_BYPASS, 16'h0000);
    // usb pin 0: push pull high, rising edge request
    wr(OFS_USB_CTL, 16'h0015);
    settle(3);
    chk("usb oe", 16'h0001, {14'h0000, usb_pad_oe});
    chk("usb out", 16'h0001, {15'h0000, usb_pad_out[0]});
    @(posedge clk);
    usb_pad_in <= 2'b01;
    wait_irq(1'b1, 1'b1);
    rd(OFS_USB_STAT, 16'h0005, "usb status");
    wr(OFS_USB_STAT, 16'h0004);
    wait_irq(1'b1, 1'b0);
    rd(8'h3c, 16'h0000, "unmapped");
    report_and_stop();
  end
endmodule : cfgio_port_test
